// ===== core/pbq_bank.sv
// biquad bank: config byte port, sample fifo, sequential cascade
`timescale 1ns/1ps
`default_nettype none
module pbq_bank (
  input wire logic CLK, // 100 MHz clock
  input wire logic SRST, // sync reset, high
  input wire logic CFG_WE, // config byte write strobe
  input wire logic [7:0] CFG_PAGE, // config page
  input wire logic [7:0] CFG_ADDR, // config register
  input wire logic [7:0] CFG_WDATA, // config byte
  input wire logic IN_VALID, // sample offered
  output logic IN_READY, // fifo has room
  input wire pbq_pkg::pbq_sample_t IN_SAMPLE, // channel and sample
  output logic OUT_VALID, // filtered sample ready
  input wire logic OUT_READY, // downstream takes sample
  output pbq_pkg::pbq_sample_t OUT_SAMPLE, // channel and sample
  output logic [1:0] ALLOC_SEL // current allocation field
);
  localparam int SW = pbq_pkg::SAMPLE_W;
  localparam int FW = $bits(pbq_pkg::pbq_sample_t);

  typedef enum logic [1:0] {S_IDLE, S_RUN, S_OUT} pbq_state_t;

  // sections assigned per channel for an allocation value
  function automatic logic [1:0] pbq_stages(input logic [1:0] sel);
    case (sel)
      2'b00: pbq_stages = 2'd0;
      2'b01: pbq_stages = 2'd1;
      2'b10: pbq_stages = 2'd2;
      default: pbq_stages = 2'd3;
    endcase
  endfunction

  // section serving a channel at a cascade stage
  function automatic logic [3:0] pbq_section(input logic [1:0] ch,
                                              input logic [1:0] stage);
    pbq_section = {stage, ch};
  endfunction

  logic [1:0] biquad_allocation_select_r;
  logic signed [31:0] coef_r [pbq_pkg::N_SECT][pbq_pkg::N_COEF];
  logic [23:0] stage_bytes_r;
  logic signed [SW-1:0] x1_r [pbq_pkg::N_SECT];
  logic signed [SW-1:0] x2_r [pbq_pkg::N_SECT];
  logic signed [SW-1:0] y1_r [pbq_pkg::N_SECT];
  logic signed [SW-1:0] y2_r [pbq_pkg::N_SECT];
  pbq_state_t state_r;
  logic [1:0] ch_r;
  logic [1:0] stage_r;
  logic [1:0] nstage_r;
  logic signed [SW-1:0] cur_r;
  logic out_valid_r;
  pbq_pkg::pbq_sample_t out_sample_r;

  // config decode
  logic coef_hit;
  logic [7:0] rel_addr;
  logic [7:0] sect_in_page;
  logic [7:0] byte_in_sect;
  logic [3:0] wr_sect;
  logic [2:0] wr_coef;
  logic [1:0] wr_byte;

  // fifo side
  logic fifo_valid;
  logic fifo_ready;
  logic [FW-1:0] fifo_data;
  pbq_pkg::pbq_sample_t head;

  // arithmetic for the active section
  logic [3:0] sec;
  logic signed [63:0] acc;
  logic signed [63:0] acc_sh;
  logic signed [SW-1:0] y_sat;

  assign ALLOC_SEL = biquad_allocation_select_r;
  assign OUT_VALID = out_valid_r;
  assign OUT_SAMPLE = out_sample_r;

  // address split into section, coefficient and byte
  always_comb begin
    coef_hit = CFG_WE
      && (CFG_PAGE == pbq_pkg::COEF_PAGE_LO
          || CFG_PAGE == pbq_pkg::COEF_PAGE_HI)
      && CFG_ADDR >= pbq_pkg::COEF_REG_FIRST
      && CFG_ADDR <= pbq_pkg::COEF_REG_LAST;
    rel_addr = CFG_ADDR - pbq_pkg::COEF_REG_FIRST;
    sect_in_page = rel_addr / pbq_pkg::SECT_BYTES;
    byte_in_sect = rel_addr % pbq_pkg::SECT_BYTES;
    wr_sect = sect_in_page[3:0]
      + ((CFG_PAGE == pbq_pkg::COEF_PAGE_HI) ?
         pbq_pkg::SECTS_PER_PAGE[3:0] : 4'h0);
    wr_coef = byte_in_sect[4:2];
    wr_byte = byte_in_sect[1:0];
  end

  // allocation field in the control byte
  always_ff @(posedge CLK) begin
    if (SRST) begin
      biquad_allocation_select_r <= pbq_pkg::ALLOC_RST;
    end else if (CFG_WE && CFG_PAGE == pbq_pkg::CTRL_PAGE
                 && CFG_ADDR == pbq_pkg::CTRL_REG) begin
      biquad_allocation_select_r <=
        CFG_WDATA[pbq_pkg::ALLOC_LSB +: 2];
    end
  end

  // upper bytes gather, lowest byte commits whole word
  always_ff @(posedge CLK) begin
    if (SRST) begin
      stage_bytes_r <= '0;
    end else if (coef_hit && wr_byte != pbq_pkg::LAST_BYTE) begin
      stage_bytes_r <= {stage_bytes_r[15:0], CFG_WDATA};
    end
  end

  // coefficient store, unity defaults, atomic word update
  always_ff @(posedge CLK) begin
    if (SRST) begin
      for (int s = 0; s < pbq_pkg::N_SECT; s++) begin
        for (int c = 0; c < pbq_pkg::N_COEF; c++) begin
          coef_r[s][c] <= (c == pbq_pkg::C_N0) ?
            pbq_pkg::N0_RST : pbq_pkg::COEF_RST;
        end
      end
    end else if (coef_hit && wr_byte == pbq_pkg::LAST_BYTE) begin
      // word swaps on its lowest byte write, in any sequencer state, even mid sample
      coef_r[wr_sect][wr_coef] <= {stage_bytes_r, CFG_WDATA};
    end
  end

  pbq_fifo #(
    .WIDTH(FW),
    .DEPTH(pbq_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clk(CLK),
    .srst(SRST),
    .in_valid(IN_VALID),
    .in_ready(IN_READY),
    .in_data(IN_SAMPLE),
    .out_valid(fifo_valid),
    .out_ready(fifo_ready),
    .out_data(fifo_data)
  );

  assign head = fifo_data;
  assign fifo_ready = (state_r == S_IDLE);

  // one section per cycle: feedforward plus feedback, q31 scaled
  always_comb begin
    sec = pbq_section(ch_r, stage_r);
    acc = 64'(coef_r[sec][pbq_pkg::C_N0] * 64'(cur_r))
      + 64'(coef_r[sec][pbq_pkg::C_N1] * 64'(x1_r[sec])) * 2
      + 64'(coef_r[sec][pbq_pkg::C_N2] * 64'(x2_r[sec]))
      + 64'(coef_r[sec][pbq_pkg::C_D1] * 64'(y1_r[sec])) * 2
      + 64'(coef_r[sec][pbq_pkg::C_D2] * 64'(y2_r[sec]));
    acc_sh = (acc + pbq_pkg::ROUND_HALF) >>> pbq_pkg::FRAC_SHIFT;
    if (acc_sh > 64'(signed'({1'b0, {(SW-1){1'b1}}}))) begin
      y_sat = {1'b0, {(SW-1){1'b1}}};
    end else if (acc_sh < 64'(signed'({1'b1, {(SW-1){1'b0}}}))) begin
      y_sat = {1'b1, {(SW-1){1'b0}}};
    end else begin
      y_sat = acc_sh[SW-1:0];
    end
  end

  // sequencer: take sample, run its sections, hand it on
  always_ff @(posedge CLK) begin
    if (SRST) begin
      state_r <= S_IDLE;
      ch_r <= '0;
      stage_r <= '0;
      nstage_r <= '0;
      cur_r <= '0;
    end else begin
      case (state_r)
        S_IDLE: begin
          if (fifo_valid) begin
            ch_r <= head.ch;
            cur_r <= head.data;
            stage_r <= '0;
            nstage_r <= pbq_stages(biquad_allocation_select_r);
            state_r <= (pbq_stages(biquad_allocation_select_r) == 2'd0)
              ? S_OUT : S_RUN;
          end
        end
        S_RUN: begin
          cur_r <= y_sat;
          stage_r <= stage_r + 1'b1;
          if (stage_r + 1'b1 == nstage_r) begin
            state_r <= S_OUT;
          end
        end
        S_OUT: begin
          if (out_valid_r && OUT_READY) begin
            state_r <= S_IDLE;
          end
        end
        default: begin
          state_r <= S_IDLE;
        end
      endcase
    end
  end

  // per section history, only the active section moves
  genvar g;
  generate
    for (g = 0; g < pbq_pkg::N_SECT; g++) begin : g_hist
      always_ff @(posedge CLK) begin
        if (SRST) begin
          x1_r[g] <= '0;
          x2_r[g] <= '0;
          y1_r[g] <= '0;
          y2_r[g] <= '0;
        end else if (state_r == S_RUN && sec == 4'(g)) begin
          x2_r[g] <= x1_r[g];
          x1_r[g] <= cur_r;
          y2_r[g] <= y1_r[g];
          y1_r[g] <= y_sat;
        end
      end
    end
  endgenerate

  // output register held until taken
  always_ff @(posedge CLK) begin
    if (SRST) begin
      out_valid_r <= 1'b0;
      out_sample_r <= '0;
    end else if (state_r == S_OUT && !out_valid_r) begin
      out_valid_r <= 1'b1;
      out_sample_r <= '{ch: ch_r, data: cur_r};
    end else if (out_valid_r && OUT_READY) begin
      out_valid_r <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// ===== core/pbq_pkg.sv
// constants and types for the playback biquad bank
// Behaviour
// - twelve sections, at most three per channel
// - each section is a two-pole two-zero recursion
// - default coefficients pass audio unchanged
// - allocation field is page 0 reg 115 bits 3:2
// - allocation 00 bypasses every channel
// - allocation 01 gives one section per channel
// - allocation 10, reset value, two per channel
// - allocation 11 gives three per channel
// - coefficients on pages 16 and 17 from reg 8
// - coefficient updates accepted while audio runs
package pbq_pkg;
  localparam int N_SECT = 12;
  localparam int N_CHAN = 4;
  localparam int MAX_PER_CHAN = 3;
  localparam int N_COEF = 5;
  localparam int SAMPLE_W = 24;
  localparam int COEF_W = 32;
  localparam int FIFO_DEPTH = 16;
  // configuration byte map
  localparam logic [7:0] CTRL_PAGE = 8'h00;
  localparam logic [7:0] CTRL_REG = 8'h73;
  localparam int ALLOC_LSB = 2;
  localparam logic [1:0] ALLOC_RST = 2'b10;
  localparam logic [7:0] COEF_PAGE_LO = 8'h10;
  localparam logic [7:0] COEF_PAGE_HI = 8'h11;
  localparam logic [7:0] COEF_REG_FIRST = 8'h08;
  localparam logic [7:0] COEF_REG_LAST = 8'h7f;
  localparam logic [7:0] SECT_BYTES = 8'h14;
  localparam logic [7:0] SECTS_PER_PAGE = 8'h06;
  localparam logic [1:0] LAST_BYTE = 2'b11;
  // coefficient order within a section
  localparam int C_N0 = 0;
  localparam int C_N1 = 1;
  localparam int C_N2 = 2;
  localparam int C_D1 = 3;
  localparam int C_D2 = 4;
  localparam logic [31:0] N0_RST = 32'h7fff_ffff;
  localparam logic [31:0] COEF_RST = 32'h0000_0000;
  localparam int FRAC_SHIFT = 31;
  localparam logic signed [63:0] ROUND_HALF = 64'h0000_0000_4000_0000;

  typedef struct packed {
    logic [1:0] ch;
    logic signed [SAMPLE_W-1:0] data;
  } pbq_sample_t;
endpackage

// ===== core/pbq_fifo.sv
// sample fifo with valid and ready on both sides
`timescale 1ns/1ps
`default_nettype none
module pbq_fifo #(
  parameter int WIDTH = 26,
  parameter int DEPTH = 16
) (
  input wire logic clk, // clock
  input wire logic srst, // sync reset, high
  input wire logic in_valid, // write request
  output logic in_ready, // room available, registered
  input wire logic [WIDTH-1:0] in_data, // write word
  output logic out_valid, // word available
  input wire logic out_ready, // reader takes word
  output logic [WIDTH-1:0] out_data // head word
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wptr_r;
  logic [AW-1:0] rptr_r;
  logic [AW:0] count_r;
  logic [AW:0] count_nxt;
  logic do_wr;
  logic do_rd;

  // handshakes
  assign do_wr = in_valid && in_ready;
  assign do_rd = out_valid && out_ready;
  assign out_valid = (count_r != '0);
  assign out_data = mem[rptr_r];

  // occupancy
  always_comb begin
    count_nxt = count_r;
    if (do_wr && !do_rd) begin
      count_nxt = count_r + 1'b1;
    end else if (do_rd && !do_wr) begin
      count_nxt = count_r - 1'b1;
    end
  end

  // pointers, count and registered ready
  always_ff @(posedge clk) begin
    if (srst) begin
      wptr_r <= '0;
      rptr_r <= '0;
      count_r <= '0;
      in_ready <= 1'b0;
    end else begin
      if (do_wr) begin
        wptr_r <= (wptr_r == AW'(DEPTH - 1)) ? '0 : wptr_r + 1'b1;
      end
      if (do_rd) begin
        rptr_r <= (rptr_r == AW'(DEPTH - 1)) ? '0 : rptr_r + 1'b1;
      end
      count_r <= count_nxt;
      in_ready <= (count_nxt != (AW+1)'(DEPTH));
    end
  end

  // storage
  always_ff @(posedge clk) begin
    if (do_wr) begin
      mem[wptr_r] <= in_data;
    end
  end
endmodule
`default_nettype wire

// ===== verif/pbq_bank_monitor.sv
// port assertions for the biquad bank
`timescale 1ns/1ps
`default_nettype none
module pbq_bank_monitor (
  input wire logic CLK, // clock
  input wire logic SRST, // sync reset
  input wire logic CFG_WE, // byte strobe
  input wire logic [7:0] CFG_PAGE, // page
  input wire logic [7:0] CFG_ADDR, // register
  input wire logic [7:0] CFG_WDATA, // byte
  input wire logic IN_VALID, // offered
  input wire logic IN_READY, // room
  input wire logic OUT_VALID, // result
  input wire logic OUT_READY, // taken
  input wire pbq_pkg::pbq_sample_t OUT_SAMPLE, // result word
  input wire logic [1:0] ALLOC_SEL // allocation
);
  logic [4:0] cnt_r;
  logic alw;
  logic tk;
  // samples taken but not yet delivered
  always_ff @(posedge CLK) begin
    if (SRST) begin
      cnt_r <= 5'h00;
    end else begin
      cnt_r <= cnt_r + 5'(IN_VALID && IN_READY) - 5'(OUT_VALID && OUT_READY);
    end
  end
  // allocation write, take with nothing in flight
  assign alw = CFG_WE && CFG_PAGE == 8'h00 && CFG_ADDR == 8'h73;
  assign tk = IN_VALID && IN_READY && cnt_r == 5'h00 && !CFG_WE;
  default clocking cb @(posedge CLK); endclocking
  default disable iff (SRST);
  property p_alw;
    alw |=> ALLOC_SEL == $past(CFG_WDATA[3:2]);
  endproperty
  a_alw: assert property (p_alw) else $error("alloc write lost");
  property p_keep;
    !alw |=> $stable(ALLOC_SEL);
  endproperty
  a_keep: assert property (p_keep) else $error("alloc moved");
  property p_rst;
    $fell(SRST) |-> ALLOC_SEL == 2'b10 && !OUT_VALID && !IN_READY;
  endproperty
  a_rst: assert property (p_rst) else $error("bad reset state");
  property p_l00;
    tk && ALLOC_SEL == 2'b00 |=> !OUT_VALID [*2] ##1 OUT_VALID;
  endproperty
  a_l00: assert property (p_l00) else $error("bypass latency");
  property p_l01;
    tk && ALLOC_SEL == 2'b01 |=> !OUT_VALID [*3] ##1 OUT_VALID;
  endproperty
  a_l01: assert property (p_l01) else $error("one stage latency");
  property p_l10;
    tk && ALLOC_SEL == 2'b10 |=> !OUT_VALID [*4] ##1 OUT_VALID;
  endproperty
  a_l10: assert property (p_l10) else $error("two stage latency");
  property p_l11;
    tk && ALLOC_SEL == 2'b11 |=> !OUT_VALID [*5] ##1 OUT_VALID;
  endproperty
  a_l11: assert property (p_l11) else $error("three stage latency");
  property p_hold;
    OUT_VALID && !OUT_READY |=> OUT_VALID && $stable(OUT_SAMPLE);
  endproperty
  a_hold: assert property (p_hold) else $error("output dropped");
  property p_cause;
    OUT_VALID |-> cnt_r != 5'h00;
  endproperty
  a_cause: assert property (p_cause) else $error("output unasked");
endmodule
bind pbq_bank pbq_bank_monitor u_mon (.CLK(CLK), .SRST(SRST), .CFG_WE(CFG_WE),
  .CFG_PAGE(CFG_PAGE), .CFG_ADDR(CFG_ADDR), .CFG_WDATA(CFG_WDATA),
  .IN_VALID(IN_VALID), .IN_READY(IN_READY), .OUT_VALID(OUT_VALID),
  .OUT_READY(OUT_READY), .OUT_SAMPLE(OUT_SAMPLE), .ALLOC_SEL(ALLOC_SEL));
`default_nettype wire

// ===== verif/pbq_host.sv
// host model writing configuration bytes
`timescale 1ns/1ps
`default_nettype none
module pbq_host (
  input wire logic clk, // clock
  output logic cfg_we, // byte strobe
  output logic [7:0] cfg_page, // page
  output logic [7:0] cfg_addr, // register
  output logic [7:0] cfg_wdata // byte
);
  // idle lines carry junk, strobe low
  initial begin
    cfg_we = 1'b0;
    cfg_page = 8'h5a;
    cfg_addr = 8'ha5;
    cfg_wdata = 8'h3c;
  end
  // one byte, then inverted lines
  task wr(input logic [7:0] p, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk); #1;
    {cfg_we, cfg_page, cfg_addr, cfg_wdata} = {1'b1, p, a, d};
    @(posedge clk); #1;
    {cfg_we, cfg_page, cfg_addr, cfg_wdata} = {1'b0, ~p, ~a, ~d};
  endtask
  // one coefficient word, msb first
  task coef(input int s, input int c, input logic [31:0] w);
    int b;
    logic [7:0] r;
    r = 8'(8 + ((s - 1) % 6) * 20 + c * 4);
    for (b = 0; b < 4; b++) begin
      wr(s > 6 ? 8'h11 : 8'h10, r + 8'(b), w[31 - 8 * b -: 8]);
    end
  endtask
  // allocation field write
  task alloc(input logic [1:0] a);
    wr(8'h00, 8'h73, {4'h0, a, 2'b00});
  endtask
endmodule
`default_nettype wire

// ===== verif/pbq_bank_test.sv
// self-checking bench for the biquad bank
`timescale 1ns/1ps
`default_nettype none
module pbq_bank_test;
  logic clk, srst, in_valid, in_ready, out_valid, out_ready, cfg_we;
  logic [7:0] cfg_page, cfg_addr, cfg_wdata;
  logic [1:0] alloc_sel;
  pbq_pkg::pbq_sample_t in_sample, out_sample, got;
  int n_mismatch = 0;
  int samples_checked = 0;
  int n, i, a, c, e;
  logic acc;
`define CHK(nm, ex, gt) begin samples_checked++; if ((gt) !== (ex)) begin \
  n_mismatch++; $display("mismatch %s exp %h got %h", nm, ex, gt); end end
  pbq_bank uut (.CLK(clk), .SRST(srst), .CFG_WE(cfg_we), .CFG_PAGE(cfg_page),
    .CFG_ADDR(cfg_addr), .CFG_WDATA(cfg_wdata), .IN_VALID(in_valid),
    .IN_READY(in_ready), .IN_SAMPLE(in_sample), .OUT_VALID(out_valid),
    .OUT_READY(out_ready), .OUT_SAMPLE(out_sample), .ALLOC_SEL(alloc_sel));
  pbq_host host (.clk(clk), .cfg_we(cfg_we), .cfg_page(cfg_page),
    .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata));
  // 100 MHz clock
  always #5 clk = ~clk;
  // verdict and end of run
  task stop_test();
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // offer one sample until taken
  task send(input int ch, input int x);
    int k;
    in_valid = 1'b1;
    in_sample = {2'(ch), 24'(x)};
    for (k = 0; k < 60 && in_ready !== 1'b1; k++) begin @(posedge clk); #1; end
    `CHK("ready", 1'b1, in_ready)
    if (in_ready !== 1'b1) stop_test();
    @(posedge clk); #1;
    in_valid = 1'b0;
  endtask
  // take one result, optionally stalling
  task recv(input logic st);
    int k;
    for (k = 0; k < 60; k++) begin
      out_ready = st ? ~out_ready : 1'b1;
      if (out_valid === 1'b1 && out_ready) begin
        got = out_sample;
        @(posedge clk); #1;
        return;
      end
      @(posedge clk); #1;
    end
    `CHK("out_valid", 1'b1, 1'b0)
    stop_test();
  endtask
  task xfer(input int ch, input int x, input int ex);
    send(ch, x);
    recv(1'b0);
    `CHK("ch", 2'(ch), got.ch)
    `CHK("data", 24'(ex), got.data)
  endtask
  task t_reset();
    `CHK("alloc", 2'b10, alloc_sel)
    host.wr(8'h01, 8'h73, 8'h00);
    @(posedge clk); #1;
    `CHK("alloc", 2'b10, alloc_sel)
  endtask
  // feedback via section 2 first-order term
  task t_recur();
    host.coef(2, 3, 32'h2000_0000);
    xfer(1, 4096, 4096);
    xfer(1, 0, 2048);
    xfer(1, 0, 1024);
    host.coef(2, 3, 32'h0000_0000);
  endtask
  // half gain in sections 7 and 12, every allocation
  task t_alloc();
    host.coef(7, 0, 32'h4000_0000);
    host.coef(12, 0, 32'h4000_0000);
    for (a = 0; a < 4; a++) begin
      host.alloc(2'(a));
      @(posedge clk); #1;
      `CHK("alloc", 2'(a), alloc_sel)
      for (c = 0; c < 4; c++) begin
        e = ((c == 2 && a >= 2) || (c == 3 && a == 3)) ? 2048 : 4096;
        xfer(c, 4096, e);
      end
    end
  endtask
  // fill until refused, update live, drain with stalls
  task t_fifo();
    host.alloc(2'b01);
    out_ready = 1'b0;
    n = 0;
    for (i = 0; i < 40; i++) begin
      in_valid = 1'b1;
      in_sample = {2'(n), 24'(n * 16)};
      acc = (in_ready === 1'b1);
      @(posedge clk); #1;
      if (acc) n++;
    end
    in_valid = 1'b0;
    `CHK("full", 1'b0, in_ready)
    `CHK("depth", 1'b1, n >= 16)
    host.coef(1, 0, 32'h4000_0000);
    for (i = 0; i < n; i++) begin
      recv(1'b1);
      e = (i % 4 == 0 && i > 0) ? i * 8 : i * 16;
      `CHK("ch", 2'(i), got.ch)
      `CHK("data", 24'(e), got.data)
    end
    out_ready = 1'b1;
    repeat (8) @(posedge clk);
    #1;
    `CHK("empty", 1'b0, out_valid)
  endtask
  // feedforward taps and negative second feedback tap, section 4
  task t_taps();
    xfer(3, 0, 0);
    xfer(3, 0, 0);
    host.coef(4, 1, 32'h2000_0000);
    host.coef(4, 2, 32'h4000_0000);
    host.coef(4, 4, 32'he000_0000);
    xfer(3, 4096, 4096);
    xfer(3, 0, 2048);
    xfer(3, 0, 1024);
    xfer(3, 0, -512);
  endtask
  // mid-run reset restores allocation and unity sections
  task t_rerst();
    srst = 1'b1;
    repeat (2) @(posedge clk);
    #1;
    srst = 1'b0;
    @(posedge clk); #1;
    `CHK("alloc", 2'b10, alloc_sel)
    xfer(3, 4096, 4096);
    xfer(3, 0, 0);
  endtask
  initial begin
    clk = 1'b0;
    srst = 1'b1;
    in_valid = 1'b0;
    in_sample = '0;
    out_ready = 1'b1;
    repeat (16) @(posedge clk);
    #1;
    srst = 1'b0;
    @(posedge clk); #1;
    t_reset();
    t_recur();
    t_alloc();
    t_fifo();
    t_taps();
    t_rerst();
    stop_test();
  end
endmodule
`default_nettype wire
